// File: verilog/rwi_map.vh
// register map, field positions and timing constants of the readout integrator
// ************************************************************
// Functional notes
// - output is the sum of each slot envelope times its same-index oscillator
// - readout mode adds all selected slots; up to sixteen tones per channel
// - spectroscopy mode uses the single channel oscillator, one tone only
// - integration starts a programmable delay after start; latency about 224 ns
// - modulation enable multiplies slot i by oscillator i, else envelope passes raw
// - input demodulated by oscillators 0 and 1, weighted, one complex result each
// - downsampling factor repeats each weight sample, lengthening the integration
// - each slot has a hold enable that pauses playback repeating one sample
// - hold starts at a programmable sample index, that sample being repeated
// - hold lasts a programmable count, then playback resumes, output lengthened
// - clear command erases every waveform slot of the channel
// - each slot plays a programmable number of envelope samples
// - each oscillator has a programmable gain scaling its contribution
// - oscillator frequency set directly or by the sequencer, which then overrides
// - sequencer start selects slots and integrators and starts both together
// ************************************************************
`ifndef RWI_MAP_VH
`define RWI_MAP_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define RWI_OFS_CTRL      8'h00
`define RWI_OFS_STATUS    8'h04
`define RWI_OFS_INT_DELAY 8'h08
`define RWI_OFS_INT_LEN   8'h0C
`define RWI_OFS_WDS       8'h10
`define RWI_OFS_WAVE_ADDR 8'h14
`define RWI_OFS_WAVE_DATA 8'h18
`define RWI_OFS_WGT_ADDR  8'h1C
`define RWI_OFS_WGT_DATA  8'h20
`define RWI_OFS_SLOT_SEL  8'h24
`define RWI_OFS_SLOT_LEN  8'h28
`define RWI_OFS_HOLD_CFG  8'h2C
`define RWI_OFS_HOLD_LEN  8'h30
`define RWI_OFS_OSC_FREQ  8'h34
`define RWI_OFS_OSC_GAIN  8'h38
`define RWI_OFS_SPEC_FREQ 8'h3C
`define RWI_OFS_RES0_RE   8'h40
`define RWI_OFS_RES0_IM   8'h44
`define RWI_OFS_RES1_RE   8'h48
`define RWI_OFS_RES1_IM   8'h4C

// ************************************************************
// field positions
// ************************************************************
`define RWI_CTRL_MOD      0
`define RWI_CTRL_SPEC     1
`define RWI_CTRL_CLEAR    2
`define RWI_CTRL_SEQF     3
`define RWI_STAT_GEN      0
`define RWI_STAT_INT      1
`define RWI_STAT_DONE     2
`define RWI_STAT_SHORT    3
`define RWI_HOLD_EN       31

// ************************************************************
// reset values and timing
// ************************************************************
`define RWI_RST_GAIN      16'h7FFF
`define RWI_RST_WDS       4'h1
`define RWI_RST_LEN       16'h1000
`define RWI_LAT_NS        224
`define RWI_CLK_MHZ       200

`endif

// File: verilog/rwi_fifo.v
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module rwi_fifo
#(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3
)
(
	// clock and reset
	input  wire             i_core_clk,
	input  wire             i_rst,
	// fill side
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	// drain side
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	wire            push;
	wire            pop;

	assign o_in_ready  = (count_reg != DEPTH[AW:0]);
	assign o_out_valid = (count_reg != {(AW+1){1'b0}});
	assign o_out_data  = mem_reg[rd_ptr_reg];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_reg[wr_ptr_reg] <= i_in_data;
				wr_ptr_reg          <= wr_ptr_reg + 1'b1;
			end
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push & ~pop)
				count_reg <= count_reg + 1'b1;
			else if (pop & ~push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule

`default_nettype wire

// File: verilog/rwi_top.v
// readout channel: waveform generator, demodulating integrator, apb registers
`include "rwi_map.vh"
`timescale 1ns/100ps
`default_nettype none

module rwi_top
#(
	parameter NSLOT  = 16,
	parameter WDEPTH = 64,
	parameter WAW    = 6,
	parameter WLEN   = 64,
	parameter WLAW   = 6
)
(
	// clock and reset
	input  wire        i_core_clk,
	input  wire        i_rst,
	// apb slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [7:0]  i_paddr,
	input  wire [31:0] i_pwdata,
	output wire [31:0] o_prdata,
	output wire        o_pready,
	output wire        o_pslverr,
	// sequencer
	input  wire        i_start,
	input  wire [15:0] i_gen_sel,
	input  wire [1:0]  i_int_sel,
	input  wire        i_seq_freq_wr,
	input  wire [3:0]  i_seq_freq_osc,
	input  wire [31:0] i_seq_freq,
	// converter output stream
	output wire        o_dac_valid,
	input  wire        i_dac_ready,
	output wire [15:0] o_dac_data,
	// converter input stream
	input  wire        i_adc_valid,
	input  wire [15:0] i_adc_data
);

	// minimum delay rounds up to whole cycles
	localparam [15:0] LAT_CYC =
		(`RWI_LAT_NS * `RWI_CLK_MHZ + 999) / 1000;

	// ************************************************************
	// helpers
	// ************************************************************
	function signed [15:0] cosf;
		input [3:0] ph;
		begin
			case (ph)
				4'h0: cosf = 16'h7FFF;
				4'h1: cosf = 16'h7642;
				4'h2: cosf = 16'h5A82;
				4'h3: cosf = 16'h30FC;
				4'h4: cosf = 16'h0000;
				4'h5: cosf = 16'hCF04;
				4'h6: cosf = 16'hA57E;
				4'h7: cosf = 16'h89BE;
				4'h8: cosf = 16'h8001;
				4'h9: cosf = 16'h89BE;
				4'hA: cosf = 16'hA57E;
				4'hB: cosf = 16'hCF04;
				4'hC: cosf = 16'h0000;
				4'hD: cosf = 16'h30FC;
				4'hE: cosf = 16'h5A82;
				default: cosf = 16'h7642;
			endcase
		end
	endfunction

	// q15 product; both operands signed
	function signed [15:0] mulq;
		input signed [15:0] a;
		input signed [15:0] b;
		reg   signed [31:0] p;
		begin
			p    = a * b;
			mulq = p[30:15];
		end
	endfunction

	// ************************************************************
	// configuration state
	// ************************************************************
	reg  [3:0]  ctrl_reg;
	reg  [15:0] int_delay_reg;
	reg  [15:0] int_len_reg;
	reg  [3:0]  wds_reg;
	reg  [19:0] wave_addr_reg;
	reg  [16:0] wgt_addr_reg;
	reg  [3:0]  slot_sel_reg;
	reg  [31:0] spec_freq_reg;
	reg  [15:0] slot_len_reg  [0:NSLOT-1];
	reg         hold_en_reg   [0:NSLOT-1];
	reg  [15:0] hold_idx_reg  [0:NSLOT-1];
	reg  [15:0] hold_len_reg  [0:NSLOT-1];
	reg  [31:0] osc_freq_reg  [0:NSLOT-1];
	reg  [31:0] seq_freq_reg  [0:NSLOT-1];
	reg  [15:0] gain_reg      [0:NSLOT-1];
	reg  [31:0] phase_reg     [0:NSLOT-1];
	reg  [31:0] spec_phase_reg;
	reg  [15:0] wave_mem      [0:NSLOT*WDEPTH-1];
	reg  [15:0] wgt_mem       [0:2*WLEN-1];

	// ************************************************************
	// apb slave, one wait state
	// ************************************************************
	reg         pready_reg;
	reg  [31:0] prdata_reg;
	reg         pslverr_reg;
	reg  [31:0] rd_next;
	reg         err_next;
	wire        acc;
	wire        wr_en;
	wire [3:0]  ss;

	assign acc       = i_psel & i_penable;
	assign wr_en     = acc & pready_reg & i_pwrite & ~pslverr_reg;
	assign o_pready  = pready_reg;
	assign o_prdata  = prdata_reg;
	assign o_pslverr = pready_reg & pslverr_reg;
	assign ss        = slot_sel_reg;

	// ************************************************************
	// generator and integrator state
	// ************************************************************
	reg         gen_act_reg;
	reg  [15:0] play_reg;
	reg  [15:0] ptr_reg       [0:NSLOT-1];
	reg  [15:0] hcnt_reg      [0:NSLOT-1];
	reg  [1:0]  int_en_reg;
	reg         int_wait_reg;
	reg         int_run_reg;
	reg         int_done_reg;
	reg  [15:0] dly_cnt_reg;
	reg  [15:0] wcnt_reg;
	reg  [3:0]  rep_reg;
	reg  signed [31:0] acc_re_reg [0:1];
	reg  signed [31:0] acc_im_reg [0:1];
	reg  signed [20:0] sum;
	reg  signed [15:0] sample;
	reg  signed [15:0] env;
	reg  signed [15:0] car;
	wire        fifo_in_ready;
	wire        adv;
	integer     s;
	integer     c;
	integer     g;
	integer     q;

	always @*
	begin
		err_next = 1'b0;
		rd_next  = 32'h0000_0000;
		case (i_paddr)
			`RWI_OFS_CTRL:      rd_next = {28'h0000000, 1'b0, ctrl_reg[2:0]} |
				{28'h0000000, ctrl_reg[3], 3'h0};
			`RWI_OFS_STATUS:    rd_next = {28'h0000000,
				(int_delay_reg < LAT_CYC), int_done_reg,
				int_wait_reg | int_run_reg, gen_act_reg};
			`RWI_OFS_INT_DELAY: rd_next = {16'h0000, int_delay_reg};
			`RWI_OFS_INT_LEN:   rd_next = {16'h0000, int_len_reg};
			`RWI_OFS_WDS:       rd_next = {28'h0000000, wds_reg};
			`RWI_OFS_WAVE_ADDR: rd_next = {12'h000, wave_addr_reg};
			`RWI_OFS_WGT_ADDR:  rd_next = {15'h0000, wgt_addr_reg};
			`RWI_OFS_SLOT_SEL:  rd_next = {28'h0000000, slot_sel_reg};
			`RWI_OFS_SLOT_LEN:  rd_next = {16'h0000, slot_len_reg[ss]};
			`RWI_OFS_HOLD_CFG:  rd_next = {hold_en_reg[ss], 15'h0000,
				hold_idx_reg[ss]};
			`RWI_OFS_HOLD_LEN:  rd_next = {16'h0000, hold_len_reg[ss]};
			`RWI_OFS_OSC_FREQ:  rd_next = osc_freq_reg[ss];
			`RWI_OFS_OSC_GAIN:  rd_next = {16'h0000, gain_reg[ss]};
			`RWI_OFS_SPEC_FREQ: rd_next = spec_freq_reg;
			`RWI_OFS_RES0_RE:   rd_next = acc_re_reg[0];
			`RWI_OFS_RES0_IM:   rd_next = acc_im_reg[0];
			`RWI_OFS_RES1_RE:   rd_next = acc_re_reg[1];
			`RWI_OFS_RES1_IM:   rd_next = acc_im_reg[1];
			`RWI_OFS_WAVE_DATA: rd_next = 32'h0000_0000;
			`RWI_OFS_WGT_DATA:  rd_next = 32'h0000_0000;
			default:            err_next = 1'b1;
		endcase
		if (i_paddr[1:0] != 2'h0)
			err_next = 1'b1;
	end

	always @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			pready_reg <= acc & ~pready_reg;
			if (acc & ~pready_reg)
			begin
				prdata_reg  <= i_pwrite ? 32'h0000_0000 : rd_next;
				pslverr_reg <= err_next;
			end
		end
	end

	// ************************************************************
	// register writes, memories, oscillators
	// ************************************************************
	always @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			ctrl_reg       <= 4'h0;
			int_delay_reg  <= LAT_CYC;
			int_len_reg    <= `RWI_RST_LEN;
			wds_reg        <= `RWI_RST_WDS;
			wave_addr_reg  <= 20'h00000;
			wgt_addr_reg   <= 17'h00000;
			slot_sel_reg   <= 4'h0;
			spec_freq_reg  <= 32'h0000_0000;
			spec_phase_reg <= 32'h0000_0000;
			for (s = 0; s < NSLOT; s = s + 1)
			begin
				slot_len_reg[s] <= `RWI_RST_LEN;
				hold_en_reg[s]  <= 1'b0;
				hold_idx_reg[s] <= 16'h0000;
				hold_len_reg[s] <= 16'h0000;
				osc_freq_reg[s] <= 32'h0000_0000;
				seq_freq_reg[s] <= 32'h0000_0000;
				gain_reg[s]     <= `RWI_RST_GAIN;
				phase_reg[s]    <= 32'h0000_0000;
			end
		end
		else
		begin
			ctrl_reg[`RWI_CTRL_CLEAR] <= 1'b0;
			for (s = 0; s < NSLOT; s = s + 1)
				phase_reg[s] <= phase_reg[s] + (ctrl_reg[`RWI_CTRL_SEQF] ?
					seq_freq_reg[s] : osc_freq_reg[s]);
			spec_phase_reg <= spec_phase_reg + spec_freq_reg;
			if (i_seq_freq_wr && ({1'b0, i_seq_freq_osc} < NSLOT))
				seq_freq_reg[i_seq_freq_osc] <= i_seq_freq;
			if (wr_en)
			begin
				case (i_paddr)
					`RWI_OFS_CTRL:      ctrl_reg      <= i_pwdata[3:0];
					`RWI_OFS_INT_DELAY: int_delay_reg <= i_pwdata[15:0];
					`RWI_OFS_INT_LEN:   int_len_reg   <= i_pwdata[15:0];
					`RWI_OFS_WDS:       wds_reg       <= i_pwdata[3:0];
					`RWI_OFS_WAVE_ADDR: wave_addr_reg <= i_pwdata[19:0];
					`RWI_OFS_WAVE_DATA:
						wave_mem[i_pwdata[31:16] == 16'h0000 ?
							wave_addr_reg[19:16] * WDEPTH +
							wave_addr_reg[WAW-1:0] : 0] <= i_pwdata[15:0];
					`RWI_OFS_WGT_ADDR:  wgt_addr_reg  <= i_pwdata[16:0];
					`RWI_OFS_WGT_DATA:
						wgt_mem[wgt_addr_reg[16] * WLEN +
							wgt_addr_reg[WLAW-1:0]] <= i_pwdata[15:0];
					`RWI_OFS_SLOT_SEL:  slot_sel_reg  <= i_pwdata[3:0];
					`RWI_OFS_SLOT_LEN:  slot_len_reg[ss] <= i_pwdata[15:0];
					`RWI_OFS_HOLD_CFG:
					begin
						hold_en_reg[ss]  <= i_pwdata[`RWI_HOLD_EN];
						hold_idx_reg[ss] <= i_pwdata[15:0];
					end
					`RWI_OFS_HOLD_LEN:  hold_len_reg[ss] <= i_pwdata[15:0];
					`RWI_OFS_OSC_FREQ:  osc_freq_reg[ss] <= i_pwdata;
					`RWI_OFS_OSC_GAIN:  gain_reg[ss]     <= i_pwdata[15:0];
					`RWI_OFS_SPEC_FREQ: spec_freq_reg    <= i_pwdata;
					default:            ctrl_reg         <= ctrl_reg;
				endcase
			end
			// the clear is a one-cycle command and overrides a same-cycle load
			if (ctrl_reg[`RWI_CTRL_CLEAR])
				for (s = 0; s < NSLOT * WDEPTH; s = s + 1)
					wave_mem[s] <= 16'h0000;
		end
	end

	// ************************************************************
	// output sample: modulate, scale, sum, saturate
	// ************************************************************
	always @*
	begin
		sum    = 21'sd0;
		env    = 16'sd0;
		car    = 16'sd0;
		sample = 16'sd0;
		c      = 0;
		if (ctrl_reg[`RWI_CTRL_SPEC])
		begin
			if (play_reg[0])
				sum = mulq(cosf(spec_phase_reg[31:28]), gain_reg[0]);
		end
		else
		begin
			for (c = 0; c < NSLOT; c = c + 1)
			begin
				if (play_reg[c])
				begin
					env = wave_mem[c * WDEPTH + ptr_reg[c][WAW-1:0]];
					car = ctrl_reg[`RWI_CTRL_MOD] ?
						mulq(env, cosf(phase_reg[c][31:28])) : env;
					sum = sum + mulq(car, gain_reg[c]);
				end
			end
		end
		if (sum > 21'sd32767)
			sample = 16'h7FFF;
		else if (sum < -21'sd32768)
			sample = 16'h8000;
		else
			sample = sum[15:0];
	end

	// ************************************************************
	// playback sequencing with per-slot hold
	// ************************************************************
	// the fifo stalls playback when the converter side holds off
	assign adv = gen_act_reg & fifo_in_ready;

	always @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			gen_act_reg <= 1'b0;
			play_reg    <= 16'h0000;
			for (g = 0; g < NSLOT; g = g + 1)
			begin
				ptr_reg[g]  <= 16'h0000;
				hcnt_reg[g] <= 16'h0000;
			end
		end
		else if (i_start)
		begin
			gen_act_reg <= (i_gen_sel != 16'h0000);
			for (g = 0; g < NSLOT; g = g + 1)
			begin
				play_reg[g] <= i_gen_sel[g] & (slot_len_reg[g] != 16'h0000);
				ptr_reg[g]  <= 16'h0000;
				hcnt_reg[g] <= 16'h0000;
			end
		end
		else if (adv)
		begin
			gen_act_reg <= 1'b0;
			for (g = 0; g < NSLOT; g = g + 1)
			begin
				if (play_reg[g])
				begin
					if (hold_en_reg[g] && ptr_reg[g] == hold_idx_reg[g] &&
						hcnt_reg[g] != hold_len_reg[g])
					begin
						hcnt_reg[g] <= hcnt_reg[g] + 16'h0001;
						gen_act_reg <= 1'b1;
					end
					else if (ptr_reg[g] + 16'h0001 == slot_len_reg[g])
						play_reg[g] <= 1'b0;
					else
					begin
						ptr_reg[g]  <= ptr_reg[g] + 16'h0001;
						gen_act_reg <= 1'b1;
					end
				end
			end
		end
	end

	rwi_fifo
	#(
		.WIDTH (16),
		.DEPTH (8),
		.AW    (3)
	)
	u_out_fifo
	(
		.i_core_clk  (i_core_clk),
		.i_rst       (i_rst),
		.i_in_valid  (gen_act_reg),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (sample),
		.o_out_valid (o_dac_valid),
		.i_out_ready (i_dac_ready),
		.o_out_data  (o_dac_data)
	);

	// ************************************************************
	// integrator: delay, demodulate, weight, accumulate
	// ************************************************************
	always @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			int_en_reg   <= 2'h0;
			int_wait_reg <= 1'b0;
			int_run_reg  <= 1'b0;
			int_done_reg <= 1'b0;
			dly_cnt_reg  <= 16'h0000;
			wcnt_reg     <= 16'h0000;
			rep_reg      <= 4'h0;
			for (q = 0; q < 2; q = q + 1)
			begin
				acc_re_reg[q] <= 32'sd0;
				acc_im_reg[q] <= 32'sd0;
			end
		end
		else if (i_start && i_int_sel != 2'h0)
		begin
			int_en_reg   <= i_int_sel;
			int_wait_reg <= 1'b1;
			int_run_reg  <= 1'b0;
			int_done_reg <= 1'b0;
			dly_cnt_reg  <= 16'h0000;
			wcnt_reg     <= 16'h0000;
			rep_reg      <= 4'h0;
			for (q = 0; q < 2; q = q + 1)
			begin
				acc_re_reg[q] <= 32'sd0;
				acc_im_reg[q] <= 32'sd0;
			end
		end
		else if (int_wait_reg)
		begin
			dly_cnt_reg <= dly_cnt_reg + 16'h0001;
			if (dly_cnt_reg + 16'h0001 >= int_delay_reg)
			begin
				int_wait_reg <= 1'b0;
				int_run_reg  <= (int_len_reg != 16'h0000);
				int_done_reg <= (int_len_reg == 16'h0000);
			end
		end
		else if (int_run_reg && i_adc_valid)
		begin
			for (q = 0; q < 2; q = q + 1)
			begin
				if (int_en_reg[q])
				begin
					acc_re_reg[q] <= acc_re_reg[q] + mulq(mulq(i_adc_data,
						cosf(phase_reg[q][31:28])),
						wgt_mem[q * WLEN + wcnt_reg[WLAW-1:0]]);
					acc_im_reg[q] <= acc_im_reg[q] - mulq(mulq(i_adc_data,
						cosf(phase_reg[q][31:28] - 4'h4)),
						wgt_mem[q * WLEN + wcnt_reg[WLAW-1:0]]);
				end
			end
			// each weight sample is used wds_reg times in a row
			if (rep_reg + 4'h1 >= wds_reg)
			begin
				rep_reg  <= 4'h0;
				wcnt_reg <= wcnt_reg + 16'h0001;
				if (wcnt_reg + 16'h0001 == int_len_reg)
				begin
					int_run_reg  <= 1'b0;
					int_done_reg <= 1'b1;
				end
			end
			else
				rep_reg <= rep_reg + 4'h1;
		end
	end

endmodule

`default_nettype wire

// File: testbench/rwi_chk_sva.sv
// port checker of the readout channel, bound to its top module
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// checker
// ************************************************************
module rwi_chk
(
	// clock and reset
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	// apb
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [7:0]  i_paddr,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	// sequencer and output stream
	input wire logic        i_start,
	input wire logic [15:0] i_gen_sel,
	input wire logic        o_dac_valid,
	input wire logic        i_dac_ready,
	input wire logic [15:0] o_dac_data
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_access;
		i_psel && i_penable && !o_pready;
	endsequence
	a_apb_two_cycle: assert property (s_setup ##1 s_access |=> o_pready)
		else $error("pready not in second access cycle");
	a_ready_single: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property (o_pready |-> $past(i_psel && i_penable))
		else $error("pready without access");
	a_err_with_ready: assert property (o_pslverr |-> o_pready)
		else $error("pslverr without pready");
	a_misalign_err: assert property ((o_pready && i_paddr[1:0] != 2'h0)
		|-> o_pslverr) else $error("misaligned access not refused");
	a_dac_valid_hold: assert property ((o_dac_valid && !i_dac_ready)
		|=> o_dac_valid) else $error("sample dropped while stalled");
	a_dac_data_hold: assert property ((o_dac_valid && !i_dac_ready)
		|=> $stable(o_dac_data)) else $error("sample changed while stalled");
	a_first_sample: assert property (
		(i_start && i_gen_sel != 16'h0 && !o_dac_valid) |-> ##2 o_dac_valid)
		else $error("first sample late after start");
	a_reset_idle: assert property ($fell(i_rst) |-> !o_dac_valid && !o_pready)
		else $error("outputs active after reset");
endmodule
bind rwi_top rwi_chk u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .i_start(i_start),
	.i_gen_sel(i_gen_sel), .o_dac_valid(o_dac_valid),
	.i_dac_ready(i_dac_ready), .o_dac_data(o_dac_data));
`default_nettype wire

// File: testbench/rwi_conv_model.sv
// converter model: output sample sink with stalls, input sample source
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// converter model
// ************************************************************
module rwi_conv_model
(
	// clock and reset
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	// control from the bench
	input wire logic [1:0]  i_mode,
	input wire logic        i_adc_en,
	// streams
	input wire logic        i_dac_valid,
	input wire logic [15:0] i_dac_data,
	output logic            o_dac_ready,
	output logic            o_adc_valid,
	output logic [15:0]     o_adc_data
);
	logic [15:0] rx [0:63];
	int          rx_n;
	logic [3:0]  tick;
	// mode 0 always ready, 1 one cycle in four, 2 never
	assign o_dac_ready = (i_mode == 2'h0) ||
		(i_mode == 2'h1 && tick[1:0] == 2'h0);
	always @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			rx_n <= 0;
			tick <= 4'h0;
			o_adc_valid <= 1'b0;
			o_adc_data <= 16'h0;
		end
		else
		begin
			tick <= tick + 4'h1;
			if (i_dac_valid && o_dac_ready)
			begin
				rx[rx_n[5:0]] <= i_dac_data;
				rx_n <= rx_n + 1;
			end
			o_adc_valid <= i_adc_en;
			// idle data flips so no one leans on a stale sample
			o_adc_data <= i_adc_en ? o_adc_data + 16'h0123 : ~o_adc_data;
		end
	end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench of the readout channel
`include "rwi_map.vh"
`timescale 1ns/100ps
`default_nettype none
`define RX(j) u_rwi_conv_model.rx[base + (j)]
`define CHK(g, e, m) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			miscompares++; \
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e); \
		end \
	end
// ************************************************************
// bench
// ************************************************************
module testbench;
	logic        i_core_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0;
	logic        i_start = 1'b0;
	logic [15:0] i_gen_sel = 16'h0;
	logic [1:0]  i_int_sel = 2'h0;
	logic        i_seq_freq_wr = 1'b0;
	logic [31:0] i_seq_freq = 32'h0;
	logic [1:0]  mode = 2'h0;
	logic        adc_en = 1'b0;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic        o_dac_valid;
	logic        i_dac_ready;
	logic [15:0] o_dac_data;
	logic        i_adc_valid;
	logic [15:0] i_adc_data;
	logic [31:0] rd;
	logic        er;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          base = 0;
	int          k;
	int          j;
	always #2.5 i_core_clk = ~i_core_clk;
	rwi_top u_rwi_top (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
		.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .i_start(i_start),
		.i_gen_sel(i_gen_sel), .i_int_sel(i_int_sel),
		.i_seq_freq_wr(i_seq_freq_wr), .i_seq_freq_osc(4'h0),
		.i_seq_freq(i_seq_freq),
		.o_dac_valid(o_dac_valid), .i_dac_ready(i_dac_ready),
		.o_dac_data(o_dac_data), .i_adc_valid(i_adc_valid),
		.i_adc_data(i_adc_data));
	rwi_conv_model u_rwi_conv_model (.i_core_clk(i_core_clk),
		.i_rst(i_rst), .i_mode(mode), .i_adc_en(adc_en),
		.i_dac_valid(o_dac_valid), .i_dac_data(o_dac_data),
		.o_dac_ready(i_dac_ready), .o_adc_valid(i_adc_valid),
		.o_adc_data(i_adc_data));
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		@(posedge i_core_clk);
		while (o_pready !== 1'b1 && n < 20)
		begin
			@(posedge i_core_clk);
			n++;
		end
		`CHK(o_pready, 1'b1, "no pready")
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic x);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e, "read data")
		`CHK(er, x, "error flag")
	endtask
	task automatic wave(input int s, input int i, input logic [15:0] v);
		apb(1'b1, `RWI_OFS_WAVE_ADDR, {12'h0, s[3:0], i[15:0]});
		apb(1'b1, `RWI_OFS_WAVE_DATA, {16'h0, v});
	endtask
	task automatic slot(input int s, input logic [31:0] g,
		input logic [31:0] h, input logic [31:0] hl);
		apb(1'b1, `RWI_OFS_SLOT_SEL, s);
		apb(1'b1, `RWI_OFS_SLOT_LEN, 32'h8);
		apb(1'b1, `RWI_OFS_OSC_GAIN, g);
		apb(1'b1, `RWI_OFS_HOLD_CFG, h);
		apb(1'b1, `RWI_OFS_HOLD_LEN, hl);
	endtask
	task automatic go(input logic [15:0] g, input logic [1:0] p);
		base = u_rwi_conv_model.rx_n;
		i_start <= 1'b1;
		i_gen_sel <= g;
		i_int_sel <= p;
		@(posedge i_core_clk);
		i_start <= 1'b0;
	endtask
	task automatic drain(input int n);
		int t;
		t = 0;
		while (u_rwi_conv_model.rx_n < base + n && t < 600)
		begin
			@(posedge i_core_clk);
			t++;
		end
		repeat (30) @(posedge i_core_clk);
		`CHK(u_rwi_conv_model.rx_n - base, n, "sample count")
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// a full run takes about 3.4 us
	initial
	begin
		#200000;
		miscompares++;
		complete_run;
	end
	initial
	begin
		repeat (8) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(posedge i_core_clk);
		apb(1'b1, `RWI_OFS_CTRL, 32'h4);
		rchk(`RWI_OFS_INT_DELAY, 32'h2D, 1'b0);
		rchk(`RWI_OFS_INT_LEN, 32'h1000, 1'b0);
		rchk(`RWI_OFS_WDS, 32'h1, 1'b0);
		rchk(`RWI_OFS_SLOT_LEN, 32'h1000, 1'b0);
		rchk(`RWI_OFS_OSC_GAIN, 32'h7FFF, 1'b0);
		rchk(8'h50, 32'h0, 1'b1);
		rchk(8'h06, 32'h0, 1'b1);
		$display("test registers done");
		for (k = 0; k < 8; k++)
		begin
			wave(0, k, 16'((k + 1) * 256));
			wave(1, k, 16'h7F80);
		end
		// half gain keeps the two-slot sum below full scale
		slot(0, 32'h4000, 32'h0, 32'h0);
		slot(1, 32'h4000, 32'h0, 32'h0);
		go(16'h1, 2'h0);
		drain(8);
		for (k = 0; k < 8; k++)
			`CHK(`RX(k), 16'((k + 1) * 128), "scaled envelope")
		$display("test slot length done");
		apb(1'b1, `RWI_OFS_SLOT_SEL, 32'h0);
		apb(1'b1, `RWI_OFS_HOLD_CFG, 32'h80000003);
		apb(1'b1, `RWI_OFS_HOLD_LEN, 32'h5);
		mode <= 2'h2;
		go(16'h1, 2'h0);
		repeat (40) @(posedge i_core_clk);
		`CHK(o_dac_valid, 1'b1, "stalled fifo valid")
		mode <= 2'h1;
		drain(13);
		for (k = 0; k < 13; k++)
		begin
			j = (k < 4) ? k : ((k < 9) ? 3 : k - 5);
			`CHK(`RX(k), 16'((j + 1) * 128), "held envelope")
		end
		mode <= 2'h0;
		apb(1'b1, `RWI_OFS_HOLD_CFG, 32'h0);
		$display("test hold done");
		go(16'h3, 2'h0);
		drain(8);
		for (k = 0; k < 8; k++)
			`CHK(`RX(k), 16'h3FC0 + 16'((k + 1) * 128), "slot sum")
		apb(1'b1, `RWI_OFS_OSC_GAIN, 32'h7FFF);
		apb(1'b1, `RWI_OFS_SLOT_SEL, 32'h1);
		apb(1'b1, `RWI_OFS_OSC_GAIN, 32'h7FFF);
		go(16'h3, 2'h0);
		drain(8);
		for (k = 0; k < 8; k++)
			`CHK(`RX(k), 16'h7FFF, "saturated sum")
		// phases are still zero; one half-turn step from the sequencer
		apb(1'b1, `RWI_OFS_CTRL, 32'h9);
		i_seq_freq_wr <= 1'b1;
		i_seq_freq <= 32'h8000_0000;
		@(posedge i_core_clk);
		i_seq_freq <= 32'h0;
		@(posedge i_core_clk);
		i_seq_freq_wr <= 1'b0;
		go(16'h1, 2'h0);
		drain(8);
		for (k = 0; k < 8; k++)
			`CHK(`RX(k), 16'(-(k + 1) * 256), "modulated slot")
		apb(1'b1, `RWI_OFS_CTRL, 32'h4);
		go(16'h3, 2'h0);
		drain(8);
		for (k = 0; k < 8; k++)
			`CHK(`RX(k), 16'h0, "cleared slot")
		// empty slots, yet the channel oscillator still gives a tone
		apb(1'b1, `RWI_OFS_CTRL, 32'h2);
		go(16'h1, 2'h0);
		drain(8);
		for (k = 0; k < 8; k++)
			`CHK(`RX(k), 16'h7FFE, "oscillator tone")
		$display("test sum and clear done");
		apb(1'b1, `RWI_OFS_INT_DELAY, 32'hA);
		apb(1'b1, `RWI_OFS_INT_LEN, 32'h6);
		apb(1'b1, `RWI_OFS_WDS, 32'h2);
		adc_en <= 1'b1;
		go(16'h0, 2'h1);
		repeat (16) @(posedge i_core_clk);
		rchk(`RWI_OFS_STATUS, 32'hA, 1'b0);
		repeat (10) @(posedge i_core_clk);
		rchk(`RWI_OFS_STATUS, 32'hC, 1'b0);
		adc_en <= 1'b0;
		$display("test integrator done");
		complete_run;
	end
endmodule
`default_nettype wire
